// >>> hdl/mcuex_core.sv
// Purpose: Executes watchdog clear, call, complement, clears, decrements
// Assumes: One instruction presented per instruction cycle on insn_word
// Notes: File data is read combinationally from the file port
//
// Notes on behaviour
// - Watchdog clear zeroes the watchdog count
// - Watchdog clear also zeroes the prescaler
// - Watchdog clear sets both active-low status bits
// - Call pushes program counter plus one
// - Call loads 11-bit target into low bits
// - Call takes upper bits from upper latch
// - Call takes two cycles, flags untouched
// - Complement inverts file, changes only zero
// - Destination bit picks accumulator or file
// - Clear file writes zero, sets zero
// - Clear accumulator writes zero, sets zero
// - Decrement subtracts one, updates only zero
// - Decrement-skip subtracts one, no flags
// - Zero decrement-skip result turns next instruction into no-op
`timescale 1ns/1ps
module mcuex_core (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic insn_valid,
    input wire logic [13:0] insn_word,
    input wire logic [7:0] pc_upper_latch,
    input wire logic [7:0] file_rdata,
    output logic [6:0] file_addr,
    output logic [7:0] file_wdata,
    output logic file_we,
    output logic [12:0] pc_out,
    output logic [12:0] stack_top,
    output logic stack_push,
    output logic [7:0] acc_out,
    output logic zero_flag,
    output logic timeout_status_n,
    output logic powerdown_status_n,
    output logic [7:0] watchdog_counter,
    output logic [7:0] watchdog_prescaler,
    output logic busy
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MCUEX_NONE, MCUEX_WDT, MCUEX_CALL, MCUEX_COMP,
        MCUEX_CLEAR_FILE_OP, MCUEX_CLEAR_ACCUMULATOR_OP, MCUEX_DEC, MCUEX_DSKIP
    } mcuex_op_t;

    typedef enum logic {MCUEX_RUN, MCUEX_STALL} mcuex_state_t;

    // Match an opcode under a mask
    function automatic logic op_match(input logic [13:0] w, input logic [13:0] pat,
                                      input logic [13:0] msk);
        op_match = ((w & msk) == pat);
    endfunction

    // Zero test of an eight-bit result
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == mcuex_pkg::ZERO_BYTE);
    endfunction

    mcuex_op_t op; // Decoded operation
    mcuex_state_t state_reg; // Run or second-cycle stall
    logic [7:0] result; // Eight-bit result of file ops
    logic to_file; // Destination bit set
    logic exec; // Instruction executes this cycle
    logic [12:0] call_target; // Assembled call address

    // Decode the presented word
    always_comb begin
        if (insn_word == mcuex_pkg::OP_WDT_CLEAR) begin
            op = MCUEX_WDT;
        end else if (op_match(insn_word, mcuex_pkg::OP_CALL, mcuex_pkg::MASK_CALL)) begin
            op = MCUEX_CALL;
        end else if (op_match(insn_word, mcuex_pkg::OP_COMP_FILE,
                              mcuex_pkg::MASK_FILE_DEST)) begin
            op = MCUEX_COMP;
        end else if (op_match(insn_word, mcuex_pkg::OP_CLR_FILE,
                              mcuex_pkg::MASK_FILE_NODEST)) begin
            op = MCUEX_CLEAR_FILE_OP;
        end else if (op_match(insn_word, mcuex_pkg::OP_CLR_ACC,
                              mcuex_pkg::MASK_CLR_ACC)) begin
            op = MCUEX_CLEAR_ACCUMULATOR_OP;
        end else if (op_match(insn_word, mcuex_pkg::OP_DEC_FILE,
                              mcuex_pkg::MASK_FILE_DEST)) begin
            op = MCUEX_DEC;
        end else if (op_match(insn_word, mcuex_pkg::OP_DEC_SKIP,
                              mcuex_pkg::MASK_FILE_DEST)) begin
            op = MCUEX_DSKIP;
        end else begin
            op = MCUEX_NONE;
        end
    end

    // Operand fields and result
    always_comb begin
        file_addr = insn_word[mcuex_pkg::FADDR_W-1:0]; // Seven-bit file address
        to_file = insn_word[mcuex_pkg::DEST_BIT];
        exec = insn_valid && (state_reg == MCUEX_RUN);
        call_target = {pc_upper_latch[mcuex_pkg::UPPER_HI:mcuex_pkg::UPPER_LO],
                       insn_word[10:0]};
        case (op)
            MCUEX_COMP: result = ~file_rdata;
            MCUEX_DEC: result = file_rdata - mcuex_pkg::BYTE_ONE;
            MCUEX_DSKIP: result = file_rdata - mcuex_pkg::BYTE_ONE;
            default: result = mcuex_pkg::ZERO_BYTE;
        endcase
    end

    // ----------------------------------------------------------------
    // File write port
    // ----------------------------------------------------------------
    // Route to file when the destination bit is one, always for clear file
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            file_we <= 1'b0;
            file_wdata <= mcuex_pkg::ZERO_BYTE;
        end else begin
            file_we <= 1'b0;
            file_wdata <= result;
            if (exec) begin
                case (op)
                    MCUEX_CLEAR_FILE_OP: begin
                        file_we <= 1'b1;
                        file_wdata <= mcuex_pkg::ZERO_BYTE;
                    end
                    MCUEX_COMP, MCUEX_DEC, MCUEX_DSKIP: file_we <= to_file;
                    default: file_we <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Accumulator and zero flag
    // ----------------------------------------------------------------
    // Accumulator takes results whose destination bit is zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_out <= mcuex_pkg::ZERO_BYTE;
        end else if (exec) begin
            case (op)
                MCUEX_CLEAR_ACCUMULATOR_OP: acc_out <= mcuex_pkg::ZERO_BYTE;
                MCUEX_COMP, MCUEX_DEC, MCUEX_DSKIP: begin
                    if (!to_file) begin
                        acc_out <= result;
                    end
                end
                default: acc_out <= acc_out;
            endcase
        end
    end

    // Zero flag; call, decrement-skip and watchdog clear leave it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            zero_flag <= 1'b0;
        end else if (exec) begin
            case (op)
                MCUEX_CLEAR_FILE_OP, MCUEX_CLEAR_ACCUMULATOR_OP: zero_flag <= 1'b1;
                MCUEX_COMP, MCUEX_DEC: zero_flag <= is_zero(result);
                default: zero_flag <= zero_flag;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Watchdog and status bits
    // ----------------------------------------------------------------
    // Watchdog clear resets count, prescaler and both status bits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            watchdog_counter <= mcuex_pkg::WDT_RESET;
            watchdog_prescaler <= mcuex_pkg::PRE_RESET;
            timeout_status_n <= 1'b1;
            powerdown_status_n <= 1'b1;
        end else if (exec && op == MCUEX_WDT) begin
            watchdog_counter <= mcuex_pkg::WDT_RESET;
            watchdog_prescaler <= mcuex_pkg::PRE_RESET;
            timeout_status_n <= 1'b1;
            powerdown_status_n <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Program counter, stack and sequencing
    // ----------------------------------------------------------------
    // Advance or branch the counter, push return address on call
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pc_out <= mcuex_pkg::PC_RESET;
            stack_top <= mcuex_pkg::PC_RESET;
            stack_push <= 1'b0;
        end else begin
            stack_push <= 1'b0;
            if (exec && op == MCUEX_CALL) begin
                stack_top <= pc_out + mcuex_pkg::PC_ONE;
                stack_push <= 1'b1;
                pc_out <= call_target;
            end else if (insn_valid && state_reg == MCUEX_RUN) begin
                pc_out <= pc_out + mcuex_pkg::PC_ONE;
            end else if (insn_valid) begin
                pc_out <= pc_out + mcuex_pkg::PC_ONE; // Discarded word is passed over
            end
        end
    end

    // Second cycle for call and for a taken skip
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= MCUEX_RUN;
        end else begin
            case (state_reg)
                MCUEX_RUN: begin
                    if (exec && op == MCUEX_CALL) begin
                        state_reg <= MCUEX_STALL;
                    end else if (exec && op == MCUEX_DSKIP && is_zero(result)) begin
                        state_reg <= MCUEX_STALL;
                    end
                end
                MCUEX_STALL: begin
                    if (insn_valid) begin
                        state_reg <= MCUEX_RUN; // Fetched word runs as no-op
                    end
                end
                default: state_reg <= MCUEX_RUN;
            endcase
        end
    end

    // Busy while the next presented word is being discarded
    always_comb begin
        busy = (state_reg == MCUEX_STALL);
    end
endmodule

// >>> hdl/mcuex_pkg.sv
// Purpose: Constants for the instruction-subset execution unit
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes: Opcode patterns are matched under masks, watchdog clear exactly
package mcuex_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int INSN_W = 14;
    localparam int FADDR_W = 7;
    localparam int WDT_W = 8;
    localparam int PRE_W = 8;
    // Opcode patterns and masks
    localparam logic [13:0] OP_WDT_CLEAR = 14'h0064;
    localparam logic [13:0] OP_CLR_ACC = 14'h0100;
    localparam logic [13:0] MASK_CLR_ACC = 14'h3f80;
    localparam logic [13:0] OP_CLR_FILE = 14'h0180;
    localparam logic [13:0] MASK_FILE_NODEST = 14'h3f80;
    localparam logic [13:0] OP_DEC_FILE = 14'h0300;
    localparam logic [13:0] OP_COMP_FILE = 14'h0900;
    localparam logic [13:0] OP_DEC_SKIP = 14'h0b00;
    localparam logic [13:0] MASK_FILE_DEST = 14'h3f00;
    localparam logic [13:0] OP_CALL = 14'h2000;
    localparam logic [13:0] MASK_CALL = 14'h3800;
    // Field positions
    localparam int DEST_BIT = 7;
    localparam int UPPER_LO = 3;
    localparam int UPPER_HI = 4;
    // Reset values and increments
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [12:0] PC_ONE = 13'h0001;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] WDT_RESET = 8'h00;
    localparam logic [7:0] PRE_RESET = 8'h00;
endpackage

// >>> tb/mcuex_core_asserts.sv
// Purpose: Port assertions for the execution unit
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to mcuex_core after the module
`timescale 1ns/1ps
module mcuex_core_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic insn_valid,
    input wire logic [13:0] insn_word,
    input wire logic [7:0] pc_upper_latch,
    input wire logic [7:0] file_rdata,
    input wire logic [6:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic file_we,
    input wire logic [12:0] pc_out,
    input wire logic [12:0] stack_top,
    input wire logic stack_push,
    input wire logic [7:0] acc_out,
    input wire logic zero_flag,
    input wire logic timeout_status_n,
    input wire logic powerdown_status_n,
    input wire logic [7:0] watchdog_counter,
    input wire logic [7:0] watchdog_prescaler,
    input wire logic busy
);
    // Decode of the word taken at this edge
    logic tk, is_wd, is_call, is_clear_file_op, is_clear_accumulator_op, is_complement_file_op, is_dsz, is_dec;
    logic [13:0] fo;
    logic [12:0] tgt, pc_inc;
    assign tk = insn_valid && !busy;
    assign fo = insn_word & mcuex_pkg::MASK_FILE_DEST;
    assign is_wd = insn_word == mcuex_pkg::OP_WDT_CLEAR;
    assign is_call = (insn_word & mcuex_pkg::MASK_CALL) == mcuex_pkg::OP_CALL;
    assign is_clear_file_op = (insn_word & mcuex_pkg::MASK_FILE_NODEST) == mcuex_pkg::OP_CLR_FILE;
    assign is_clear_accumulator_op = (insn_word & mcuex_pkg::MASK_CLR_ACC) == mcuex_pkg::OP_CLR_ACC;
    assign is_complement_file_op = fo == mcuex_pkg::OP_COMP_FILE;
    assign is_dsz = fo == mcuex_pkg::OP_DEC_SKIP;
    assign is_dec = fo == mcuex_pkg::OP_DEC_FILE;
    assign tgt = {pc_upper_latch[4:3], insn_word[10:0]};
    assign pc_inc = pc_out + 13'h0001;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Discard cycle, then free again unless no word arrived to discard
    sequence call_tail;
        busy ##1 (!busy || !$past(insn_valid));
    endsequence
    AST_WDT_CLEAR: assert property (tk && is_wd |=>
        {watchdog_counter, watchdog_prescaler, timeout_status_n, powerdown_status_n} == 18'h00003)
        else $error("watchdog clear wrong");
    AST_CALL_PUSH: assert property (tk && is_call |=>
        stack_push && stack_top == $past(pc_inc))
        else $error("call push wrong");
    AST_CALL_TARGET: assert property (tk && is_call |=>
        pc_out == $past(tgt))
        else $error("call target wrong");
    AST_CALL_TWO: assert property (tk && is_call |=>
        $stable(zero_flag) ##0 call_tail)
        else $error("call timing wrong");
    AST_COMP_FILE: assert property (tk && is_complement_file_op && insn_word[7] |=>
        file_we && file_wdata == ~$past(file_rdata) && zero_flag == ($past(file_rdata) == 8'hff))
        else $error("complement wrong");
    AST_CLR_FILE: assert property (tk && is_clear_file_op |=>
        file_we && file_wdata == 8'h00 && zero_flag)
        else $error("clear file wrong");
    AST_CLR_ACC: assert property (tk && is_clear_accumulator_op |=>
        acc_out == 8'h00 && zero_flag)
        else $error("clear accumulator wrong");
    AST_DEC_SKIP: assert property (tk && is_dsz |=>
        $stable(zero_flag) && busy == ($past(file_rdata) == 8'h01))
        else $error("decrement skip wrong");
    // Decrement into the accumulator, zero flag from the result
    AST_DEC_ACC: assert property (tk && is_dec && !insn_word[7] |=>
        !file_we && acc_out == $past(file_rdata) - 8'h01 &&
        zero_flag == ($past(file_rdata) == 8'h01))
        else $error("decrement to accumulator wrong");
    // A discarded word only advances the counter
    AST_SKIP_NOP: assert property (busy && insn_valid |=>
        !file_we && !stack_push && !busy && $stable(acc_out) && $stable(zero_flag) &&
        pc_out == $past(pc_inc))
        else $error("discarded word not a no-op");
    // File address follows the word's address field
    AST_FILE_ADDR: assert property (file_addr == insn_word[6:0])
        else $error("file address wrong");
endmodule
bind mcuex_core mcuex_core_asserts mcuex_core_asserts_inst (.ref_clk, .rst, .insn_valid,
    .insn_word, .pc_upper_latch, .file_rdata, .file_addr, .file_wdata, .file_we, .pc_out,
    .stack_top,
    .stack_push, .acc_out, .zero_flag, .timeout_status_n, .powerdown_status_n,
    .watchdog_counter, .watchdog_prescaler, .busy);

// >>> tb/mcuex_core_bench.sv
// Purpose: Self-checking bench for the execution unit
// Assumes: Results show at the edge that takes a word, checked at the next falling edge
// Notes: Driver queues expected notes, a monitor compares them
`timescale 1ns/1ps
module mcuex_core_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic insn_valid = 1'b0;
    logic [13:0] insn_word = 14'h0000;
    logic [7:0] pc_upper_latch = 8'h00;
    logic [7:0] file_rdata = 8'h00;
    logic [6:0] file_addr;
    logic [7:0] file_wdata, acc_out, watchdog_counter, watchdog_prescaler;
    logic [12:0] pc_out, stack_top;
    logic file_we, stack_push, zero_flag, timeout_status_n, powerdown_status_n, busy;
    logic [63:0] seen;
    logic [63:0] notes [$];
    // Reference model state
    logic [7:0] m_acc = 8'h00;
    logic [12:0] m_pc = 13'h0000;
    logic m_z = 1'b0;
    logic m_busy = 1'b0;
    logic [13:0] dw [12] = '{14'h0305, 14'h27ff, 14'h0100, 14'h0b8a, 14'h0183, 14'h09c4,
        14'h0b11, 14'h0922, 14'h01ff, 14'h03a0, 14'h0064, 14'h0b00};
    logic [7:0] dr [12] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hff, 8'h02, 8'h5a, 8'h00,
        8'h01, 8'h00, 8'h00};
    int err_count = 0;
    int cmp_count = 0;
    int seed = 32'h035e4c34;
    int r;
    int k;
    always #50 ref_clk = ~ref_clk;
    mcuex_core mcuex_core_inst (.ref_clk, .rst, .insn_valid, .insn_word, .pc_upper_latch,
        .file_rdata, .file_addr, .file_wdata, .file_we, .pc_out, .stack_top, .stack_push,
        .acc_out, .zero_flag, .timeout_status_n, .powerdown_status_n, .watchdog_counter,
        .watchdog_prescaler, .busy);
    // Outputs as one note; write data and stack only count when strobed
    assign seen = {acc_out, zero_flag, pc_out, file_we, file_we ? file_wdata : 8'h00,
        stack_push, stack_push ? stack_top : 13'h0000, busy, timeout_status_n,
        powerdown_status_n, watchdog_counter, watchdog_prescaler};
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        // Any notes never compared count as one mismatch
        if (notes.size() != 0) begin
            err_count++;
        end
        $display("Compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Drive one word at this edge, predict, note the result after the taking edge
    task automatic step(input logic v, input logic [13:0] wd, input logic [7:0] rd,
        input logic [7:0] up);
        logic [13:0] f;
        logic [7:0] res, fw;
        logic [12:0] st;
        logic we, psh, cl, ca, cf;
        insn_valid <= v;
        insn_word <= wd;
        file_rdata <= rd;
        pc_upper_latch <= up;
        cl = (wd & mcuex_pkg::MASK_CALL) == mcuex_pkg::OP_CALL;
        ca = (wd & mcuex_pkg::MASK_CLR_ACC) == mcuex_pkg::OP_CLR_ACC;
        cf = (wd & mcuex_pkg::MASK_FILE_NODEST) == mcuex_pkg::OP_CLR_FILE;
        f = wd & mcuex_pkg::MASK_FILE_DEST;
        res = (f == mcuex_pkg::OP_COMP_FILE) ? ~rd : rd - 8'h01;
        {we, psh, fw, st} = '0;
        if (v) begin
            m_pc = m_pc + 13'h0001;
            if (m_busy) begin
                m_busy = 1'b0; // Discarded word
            end else if (cl) begin
                {psh, st} = {1'b1, m_pc};
                m_pc = {up[4:3], wd[10:0]};
                m_busy = 1'b1;
            end else if (ca) begin
                {m_acc, m_z} = 9'h001;
            end else if (cf) begin
                {we, m_z} = 2'b11;
            end else if (f == mcuex_pkg::OP_DEC_FILE || f == mcuex_pkg::OP_COMP_FILE ||
                f == mcuex_pkg::OP_DEC_SKIP) begin
                if (f == mcuex_pkg::OP_DEC_SKIP) m_busy = res == 8'h00;
                else m_z = res == 8'h00;
                if (wd[7]) {we, fw} = {1'b1, res};
                else m_acc = res;
            end
        end
        @(posedge ref_clk);
        notes.push_back({m_acc, m_z, m_pc, we, fw, psh, st, m_busy, 2'b11, 16'h0000});
    endtask
    // Monitor compares the oldest note once outputs have settled
    always @(negedge ref_clk) begin
        if (notes.size() > 0) begin
            chk(seen, notes.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        step(1'b0, 14'h0000, 8'h00, 8'h00);
        foreach (dw[i]) step(1'b1, dw[i], dr[i], 8'h18);
        $display("Test directed sequence done");
        for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            k = int'(r[3:0]) % 12;
            step(r[4] | r[5], dw[k] ^ (14'(r) & 14'h007f), r[6] ? 8'h01 : r[15:8], r[23:16]);
        end
        @(posedge ref_clk);
        $display("Test random sequence done");
        print_verdict;
    end
endmodule
